// >>> rtl/exec_pkg.sv
// Purpose: Shared constants and types for the block move, search and arithmetic unit.
// Assumes: 16-bit register port data, 8-bit external memory data.
// Notes: Register indices are word positions on the register port.
package exec_pkg;

	// ----------------------------------------------------------------
	// Register port map
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_PC = 4'h2;
	localparam logic [3:0] REG_AF = 4'h3;
	localparam logic [3:0] REG_BC = 4'h4;
	localparam logic [3:0] REG_DE = 4'h5;
	localparam logic [3:0] REG_HL = 4'h6;
	localparam logic [3:0] REG_IX = 4'h7;
	localparam logic [3:0] REG_IY = 4'h8;
	localparam logic [3:0] REG_SP = 4'h9;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_ABORT_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_UNSUP_BIT = 2;
	localparam int STAT_ABORT_BIT = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// Flag bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_N = 1;
	localparam int FLAG_PV = 2;
	localparam int FLAG_X = 3;
	localparam int FLAG_H = 4;
	localparam int FLAG_Y = 5;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 7;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_EXT = 8'hED;
	localparam logic [7:0] OP_IDX_X = 8'hDD;
	localparam logic [7:0] OP_IDX_Y = 8'hFD;
	localparam logic [7:0] OP_NEGATE = 8'h44;
	localparam logic [7:0] OP_DECADJ = 8'h27;
	localparam logic [7:0] OP_CPLACC = 8'h2F;
	localparam logic [7:0] OP_SETC = 8'h37;
	localparam logic [7:0] OP_INVC = 8'h3F;
	localparam logic [2:0] R_MEM = 3'd6;
	localparam logic [2:0] R_ACC = 3'd7;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_XOR, ALU_OR, ALU_CP,
		ALU_INC, ALU_DEC, ALU_DAA, ALU_CPL, ALU_NEG, ALU_SCF, ALU_CCF
	} alu_op_type;

	typedef enum logic [2:0] {
		CL_NONE, CL_BLOCK, CL_ADC16, CL_ALU, CL_INCDEC, CL_UTIL
	} class_type;

	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_RD_WAIT, S_OPCODE, S_DISP, S_LATCH, S_BLOCK, S_EXEC
	} state_type;

endpackage

// >>> rtl/alu8.sv
// Purpose: 8-bit arithmetic, logic and accumulator utility operations with flags.
// Assumes: Purely combinational; caller selects operands.
// Notes: Negate is fed as zero minus the accumulator by the caller.
`timescale 1ns/1ps
module alu8
	import exec_pkg::*;
(
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] flags_in,
	input wire alu_op_type op,
	output logic [7:0] result,
	output logic [7:0] flags_out
);

	logic cin;
	logic [8:0] sum9;
	logic [8:0] dif9;
	logic [7:0] corr;
	logic daa_c;
	logic [7:0] daa_r;

	assign cin = ((op == ALU_ADC) || (op == ALU_SBC)) ? flags_in[FLAG_C] : 1'b0;
	assign sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	assign dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
	assign daa_c = flags_in[FLAG_C] || (a > 8'h99);
	assign corr = {1'b0, daa_c, daa_c, 2'b00, (flags_in[FLAG_H] || (a[3:0] > 4'h9)),
		(flags_in[FLAG_H] || (a[3:0] > 4'h9)), 1'b0};
	// The subtract flag picks the correction direction.
	assign daa_r = flags_in[FLAG_N] ? (a - corr) : (a + corr);

	always_comb
	begin
		result = a;
		flags_out = flags_in;
		case (op)
			ALU_ADD, ALU_ADC, ALU_INC:
			begin
				result = sum9[7:0];
				flags_out[FLAG_H] = a[4] ^ b[4] ^ sum9[4];
				flags_out[FLAG_PV] = (a[7] == b[7]) && (sum9[7] != a[7]);
				flags_out[FLAG_N] = 1'b0;
				if (op != ALU_INC)
					flags_out[FLAG_C] = sum9[8];
			end
			ALU_SUB, ALU_SBC, ALU_CP, ALU_DEC, ALU_NEG:
			begin
				result = (op == ALU_CP) ? a : dif9[7:0];
				flags_out[FLAG_H] = a[4] ^ b[4] ^ dif9[4];
				flags_out[FLAG_PV] = (a[7] != b[7]) && (dif9[7] != a[7]);
				flags_out[FLAG_N] = 1'b1;
				if (op != ALU_DEC)
					flags_out[FLAG_C] = dif9[8];
			end
			ALU_AND, ALU_XOR, ALU_OR:
			begin
				result = (op == ALU_AND) ? (a & b) : ((op == ALU_OR) ? (a | b) : (a ^ b));
				flags_out[FLAG_H] = (op == ALU_AND);
				flags_out[FLAG_PV] = ~^result;
				flags_out[FLAG_N] = 1'b0;
				flags_out[FLAG_C] = 1'b0;
			end
			ALU_DAA:
			begin
				result = daa_r;
				flags_out[FLAG_H] = flags_in[FLAG_N] ? (flags_in[FLAG_H] && (a[3:0] < 4'h6))
					: (a[3:0] > 4'h9);
				flags_out[FLAG_PV] = ~^daa_r;
				flags_out[FLAG_C] = daa_c;
			end
			ALU_CPL:
			begin
				result = ~a;
				flags_out[FLAG_H] = 1'b1;
				flags_out[FLAG_N] = 1'b1;
			end
			ALU_SCF:
			begin
				flags_out[FLAG_C] = 1'b1;
				flags_out[FLAG_H] = 1'b0;
				flags_out[FLAG_N] = 1'b0;
			end
			ALU_CCF:
			begin
				flags_out[FLAG_H] = flags_in[FLAG_C];
				flags_out[FLAG_C] = ~flags_in[FLAG_C];
				flags_out[FLAG_N] = 1'b0;
			end
			default:
			begin
				result = a;
			end
		endcase
		if ((op != ALU_SCF) && (op != ALU_CCF))
		begin
			flags_out[FLAG_S] = result[7];
			flags_out[FLAG_Z] = (result == 8'h00);
			flags_out[FLAG_Y] = result[5];
			flags_out[FLAG_X] = result[3];
		end
		if (op == ALU_CP)
		begin
			flags_out[FLAG_S] = dif9[7];
			flags_out[FLAG_Z] = (dif9[7:0] == 8'h00);
			flags_out[FLAG_Y] = b[5];
			flags_out[FLAG_X] = b[3];
		end
	end

endmodule

// >>> rtl/block_move_search_arith_exec.sv
// Purpose: Fetches and executes block move, block search and arithmetic instructions.
// Assumes: External memory answers a read one cycle after the read strobe.
// Notes: Software loads the registers while idle, then starts execution.
`timescale 1ns/1ps
module block_move_search_arith_exec
	import exec_pkg::*;
#(
	parameter int BUS_AW = 4
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [BUS_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata
);

	if (BUS_AW < 4)
	begin : g_check
		$error("BUS_AW must be at least 4");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic class_type classify(input logic ed, input logic [7:0] op);
		class_type c;
		c = CL_NONE;
		if (ed)
		begin
			if ((op[7:5] == 3'b101) && (op[2:1] == 2'b00))
				c = CL_BLOCK;
			else if ((op[7:6] == 2'b01) && (op[2:0] == 3'b010))
				c = CL_ADC16;
			else if (op == OP_NEGATE)
				c = CL_UTIL;
		end
		else if ((op[7:6] == 2'b10) || ((op[7:6] == 2'b11) && (op[2:0] == R_MEM)))
			c = CL_ALU;
		else if ((op[7:6] == 2'b00) && (op[2:1] == 2'b10))
			c = CL_INCDEC;
		else if ((op == OP_DECADJ) || (op == OP_CPLACC) || (op == OP_SETC) || (op == OP_INVC))
			c = CL_UTIL;
		return c;
	endfunction

	function automatic logic [7:0] get_r(input logic [2:0] r, input logic [15:0] bc,
		input logic [15:0] de, input logic [15:0] hl, input logic [7:0] acc);
		logic [7:0] v;
		v = acc;
		case (r)
			3'd0: v = bc[15:8];
			3'd1: v = bc[7:0];
			3'd2: v = de[15:8];
			3'd3: v = de[7:0];
			3'd4: v = hl[15:8];
			3'd5: v = hl[7:0];
			default: v = acc;
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_type state_reg;
	state_type ret_reg;
	logic [15:0] pc_reg, bc_reg, de_reg, hl_reg, ix_reg, iy_reg, sp_reg, ea_reg;
	logic [7:0] acc_reg, f_reg, op_reg, opnd_reg;
	logic ed_reg;
	logic [1:0] idx_reg;
	logic done_reg, unsup_reg, abort_reg;
	logic [15:0] reg_rdata_reg, mem_addr_reg;
	logic mem_rd_reg, mem_wr_reg;
	logic [7:0] mem_wdata_reg;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	class_type cls_in, cls_op;
	logic [2:0] rsrc_in, rdst;
	logic need_mem_in, imm_in, idle, sw_wr, blk_search, blk_down, blk_rep, is_neg;
	logic [15:0] idx_base, step, bc_dec, ss_val, disp_addr;
	logic [16:0] sum17, dif17, r17;
	logic [7:0] f16, alu_a, alu_b, alu_res, alu_f, rd_mux;
	alu_op_type alu_sel;

	assign idle = (state_reg == S_IDLE);
	assign sw_wr = reg_wr && idle;
	assign cls_in = classify(ed_reg, mem_rdata);
	assign cls_op = classify(ed_reg, op_reg);
	assign rsrc_in = (cls_in == CL_INCDEC) ? mem_rdata[5:3] : mem_rdata[2:0];
	assign imm_in = (mem_rdata[7:6] == 2'b11);
	assign need_mem_in = (rsrc_in == R_MEM) && (((cls_in == CL_ALU) && !imm_in)
		|| (cls_in == CL_INCDEC));
	assign idx_base = (idx_reg == 2'd2) ? iy_reg : ix_reg;
	assign disp_addr = idx_base + {{8{mem_rdata[7]}}, mem_rdata};
	assign rdst = op_reg[5:3];
	assign blk_search = op_reg[0];
	assign blk_down = op_reg[3];
	assign blk_rep = op_reg[4];
	assign is_neg = ed_reg && (op_reg == OP_NEGATE);
	assign step = blk_down ? 16'hFFFF : 16'h0001;
	assign bc_dec = bc_reg - 16'h0001;

	assign ss_val = (op_reg[5:4] == 2'd0) ? bc_reg : (op_reg[5:4] == 2'd1) ? de_reg
		: (op_reg[5:4] == 2'd2) ? hl_reg : sp_reg;
	assign sum17 = {1'b0, hl_reg} + {1'b0, ss_val} + {16'h0000, f_reg[FLAG_C]};
	assign dif17 = {1'b0, hl_reg} - {1'b0, ss_val} - {16'h0000, f_reg[FLAG_C]};
	assign r17 = op_reg[3] ? sum17 : dif17;
	assign f16 = {r17[15], (r17[15:0] == 16'h0000), r17[13],
		hl_reg[12] ^ ss_val[12] ^ r17[12], r17[11],
		op_reg[3] ? ((hl_reg[15] == ss_val[15]) && (r17[15] != hl_reg[15]))
		: ((hl_reg[15] != ss_val[15]) && (r17[15] != hl_reg[15])),
		!op_reg[3], r17[16]};

	assign alu_sel = (cls_op == CL_ALU) ? alu_op_type'({1'b0, op_reg[5:3]})
		: (cls_op == CL_INCDEC) ? (op_reg[0] ? ALU_DEC : ALU_INC)
		: (cls_op == CL_BLOCK) ? ALU_CP
		: is_neg ? ALU_NEG
		: (op_reg == OP_DECADJ) ? ALU_DAA
		: (op_reg == OP_CPLACC) ? ALU_CPL
		: (op_reg == OP_SETC) ? ALU_SCF : ALU_CCF;
	assign alu_a = (cls_op == CL_INCDEC) ? opnd_reg : (is_neg ? 8'h00 : acc_reg);
	assign alu_b = (cls_op == CL_INCDEC) ? 8'h01 : (is_neg ? acc_reg : opnd_reg);

	alu8 u_alu (
		.a(alu_a),
		.b(alu_b),
		.flags_in(f_reg),
		.op(alu_sel),
		.result(alu_res),
		.flags_out(alu_f)
	);

	// ----------------------------------------------------------------
	// Register port read
	// ----------------------------------------------------------------
	assign rd_mux = 8'h00;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata_reg <= RST_WORD;
		else if (!reg_rd)
			reg_rdata_reg <= RST_WORD;
		else
			case (reg_addr)
				REG_STATUS: reg_rdata_reg <= {12'h000, abort_reg, unsup_reg, done_reg, !idle};
				REG_PC: reg_rdata_reg <= pc_reg;
				REG_AF: reg_rdata_reg <= {acc_reg, f_reg};
				REG_BC: reg_rdata_reg <= bc_reg;
				REG_DE: reg_rdata_reg <= de_reg;
				REG_HL: reg_rdata_reg <= hl_reg;
				REG_IX: reg_rdata_reg <= ix_reg;
				REG_IY: reg_rdata_reg <= iy_reg;
				REG_SP: reg_rdata_reg <= sp_reg;
				default: reg_rdata_reg <= {8'h00, rd_mux};
			endcase
	end

	// ----------------------------------------------------------------
	// Sequencer and datapath registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= S_IDLE;
			ret_reg <= S_IDLE;
			{pc_reg, bc_reg, de_reg, hl_reg} <= {4{RST_WORD}};
			{ix_reg, iy_reg, sp_reg, ea_reg, mem_addr_reg} <= {5{RST_WORD}};
			{acc_reg, f_reg, op_reg, opnd_reg, mem_wdata_reg} <= {5{RST_BYTE}};
			{ed_reg, idx_reg, done_reg, unsup_reg, abort_reg, mem_rd_reg, mem_wr_reg} <= '0;
		end
		else
		begin
			mem_rd_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			if (reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_ABORT_BIT] && !idle)
				abort_reg <= 1'b1;
			if (sw_wr)
				case (reg_addr)
					REG_CTRL:
						if (reg_wdata[CTRL_START_BIT])
						begin
							state_reg <= S_FETCH;
							{done_reg, unsup_reg, abort_reg} <= 3'b000;
						end
					REG_PC: pc_reg <= reg_wdata;
					REG_AF: {acc_reg, f_reg} <= reg_wdata;
					REG_BC: bc_reg <= reg_wdata;
					REG_DE: de_reg <= reg_wdata;
					REG_HL: hl_reg <= reg_wdata;
					REG_IX: ix_reg <= reg_wdata;
					REG_IY: iy_reg <= reg_wdata;
					REG_SP: sp_reg <= reg_wdata;
					default: ;
				endcase
			case (state_reg)
				S_IDLE: ;
				S_FETCH:
				begin
					ed_reg <= 1'b0;
					idx_reg <= 2'd0;
					if (abort_reg)
					begin
						state_reg <= S_IDLE;
						done_reg <= 1'b1;
					end
					else
					begin
						mem_addr_reg <= pc_reg;
						mem_rd_reg <= 1'b1;
						pc_reg <= pc_reg + 16'h0001;
						ret_reg <= S_OPCODE;
						state_reg <= S_RD_WAIT;
					end
				end
				S_RD_WAIT: state_reg <= ret_reg;
				S_OPCODE:
				begin
					op_reg <= mem_rdata;
					if (!ed_reg && ((mem_rdata == OP_EXT) || (mem_rdata == OP_IDX_X)
						|| (mem_rdata == OP_IDX_Y)))
					begin
						ed_reg <= (mem_rdata == OP_EXT);
						idx_reg <= (mem_rdata == OP_IDX_X) ? 2'd1
							: (mem_rdata == OP_IDX_Y) ? 2'd2 : idx_reg;
						mem_addr_reg <= pc_reg;
						mem_rd_reg <= 1'b1;
						pc_reg <= pc_reg + 16'h0001;
						ret_reg <= S_OPCODE;
						state_reg <= S_RD_WAIT;
					end
					else if (cls_in == CL_NONE)
					begin
						{unsup_reg, done_reg} <= 2'b11;
						state_reg <= S_IDLE;
					end
					else if (cls_in == CL_BLOCK)
						state_reg <= S_BLOCK;
					else if ((need_mem_in && (idx_reg != 2'd0)) || ((cls_in == CL_ALU) && imm_in))
					begin
						// Displacement or immediate sits right after the operation code.
						mem_addr_reg <= pc_reg;
						mem_rd_reg <= 1'b1;
						pc_reg <= pc_reg + 16'h0001;
						ret_reg <= (cls_in == CL_ALU) && imm_in ? S_LATCH : S_DISP;
						state_reg <= S_RD_WAIT;
					end
					else if (need_mem_in)
					begin
						ea_reg <= hl_reg;
						mem_addr_reg <= hl_reg;
						mem_rd_reg <= 1'b1;
						ret_reg <= S_LATCH;
						state_reg <= S_RD_WAIT;
					end
					else
					begin
						opnd_reg <= get_r(rsrc_in, bc_reg, de_reg, hl_reg, acc_reg);
						state_reg <= S_EXEC;
					end
				end
				S_DISP:
				begin
					ea_reg <= disp_addr;
					mem_addr_reg <= disp_addr;
					mem_rd_reg <= 1'b1;
					ret_reg <= S_LATCH;
					state_reg <= S_RD_WAIT;
				end
				S_LATCH:
				begin
					opnd_reg <= mem_rdata;
					state_reg <= S_EXEC;
				end
				S_BLOCK:
				begin
					mem_addr_reg <= hl_reg;
					mem_rd_reg <= 1'b1;
					ret_reg <= S_LATCH;
					state_reg <= S_RD_WAIT;
				end
				S_EXEC:
				begin
					state_reg <= S_FETCH;
					case (cls_op)
						CL_BLOCK:
						begin
							hl_reg <= hl_reg + step;
							bc_reg <= bc_dec;
							if (blk_search)
							begin
								// Carry is left alone by a search step.
								f_reg <= {alu_f[7:3], (bc_dec != 16'h0000), 1'b1, f_reg[FLAG_C]};
								if (blk_rep && (bc_dec != 16'h0000) && !alu_f[FLAG_Z])
									state_reg <= S_BLOCK;
							end
							else
							begin
								de_reg <= de_reg + step;
								mem_addr_reg <= de_reg;
								mem_wdata_reg <= opnd_reg;
								mem_wr_reg <= 1'b1;
								f_reg[FLAG_H] <= 1'b0;
								f_reg[FLAG_N] <= 1'b0;
								f_reg[FLAG_PV] <= (bc_dec != 16'h0000);
								if (blk_rep && (bc_dec != 16'h0000))
									state_reg <= S_BLOCK;
							end
						end
						CL_ADC16:
						begin
							hl_reg <= r17[15:0];
							f_reg <= f16;
						end
						CL_INCDEC:
						begin
							f_reg <= alu_f;
							if (rdst == R_MEM)
							begin
								mem_addr_reg <= ea_reg;
								mem_wdata_reg <= alu_res;
								mem_wr_reg <= 1'b1;
							end
							else
								case (rdst)
									3'd0: bc_reg[15:8] <= alu_res;
									3'd1: bc_reg[7:0] <= alu_res;
									3'd2: de_reg[15:8] <= alu_res;
									3'd3: de_reg[7:0] <= alu_res;
									3'd4: hl_reg[15:8] <= alu_res;
									3'd5: hl_reg[7:0] <= alu_res;
									default: acc_reg <= alu_res;
								endcase
						end
						default:
						begin
							f_reg <= alu_f;
							acc_reg <= alu_res;
						end
					endcase
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_rd = mem_rd_reg;
	assign mem_wr = mem_wr_reg;
	assign mem_wdata = mem_wdata_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_move_exec;
		(state_reg == S_EXEC) && (cls_op == CL_BLOCK) && !blk_search;
	endsequence
	sequence s_search_exec;
		(state_reg == S_EXEC) && (cls_op == CL_BLOCK) && blk_search;
	endsequence

	a_move_up_step: assert property (@(posedge clk) disable iff (!nrst)
		s_move_exec and !blk_down |=> (hl_reg == $past(hl_reg) + 16'h0001)
		&& (de_reg == $past(de_reg) + 16'h0001) && mem_wr && (mem_addr == $past(de_reg))
		&& (mem_wdata == $past(opnd_reg)))
		else $error("move step up wrong");
	a_move_repeat_loop: assert property (@(posedge clk) disable iff (!nrst)
		s_move_exec and blk_rep and (bc_dec != 16'h0000) |=> (state_reg == S_BLOCK)
		##1 (mem_rd && (mem_addr == hl_reg)))
		else $error("repeat move did not continue");
	a_move_down_ptrs: assert property (@(posedge clk) disable iff (!nrst)
		s_move_exec and blk_down |=> (hl_reg == $past(hl_reg) - 16'h0001)
		&& (de_reg == $past(de_reg) - 16'h0001))
		else $error("move step down wrong");
	a_search_zero_flag: assert property (@(posedge clk) disable iff (!nrst)
		s_search_exec |=> (f_reg[FLAG_Z] == ($past(opnd_reg) == $past(acc_reg)))
		&& (hl_reg == $past(hl_reg) + $past(step)) && !mem_wr)
		else $error("search compare flag wrong");
	a_search_match_stop: assert property (@(posedge clk) disable iff (!nrst)
		s_search_exec and (opnd_reg == acc_reg) |=> (state_reg == S_FETCH))
		else $error("search did not stop on match");
	a_count_wraps: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == S_EXEC) && (cls_op == CL_BLOCK) && (bc_reg == 16'h0000)
		|=> (bc_reg == 16'hFFFF))
		else $error("counter did not wrap");
	a_cp_keeps_acc: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == S_EXEC) && (cls_op == CL_ALU) && (op_reg[5:3] == 3'd7)
		|=> $stable(acc_reg))
		else $error("compare changed accumulator");
	a_neg_twos: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == S_EXEC) && is_neg |=> (acc_reg == 8'h00 - $past(acc_reg)))
		else $error("negate wrong");
	a_disp_address: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == S_DISP) |=> mem_rd && (mem_addr == $past(disp_addr)))
		else $error("indexed address wrong");
	a_adc16_result: assert property (@(posedge clk) disable iff (!nrst)
		(state_reg == S_EXEC) && (cls_op == CL_ADC16) |=> (hl_reg == $past(r17[15:0]))
		&& (f_reg[FLAG_N] == !$past(op_reg[3])) && (f_reg[FLAG_C] == $past(r17[16])))
		else $error("16-bit carry arithmetic wrong");

endmodule

// >>> tb/ext_mem.sv
// Purpose: External memory model holding program and data bytes.
// Assumes: Read data stand only in the cycle after mem_rd.
// Notes: Outside that cycle the data lines show the inverse.
`timescale 1ns/1ps
module ext_mem
(
	input wire logic clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] q = 8'h00;
	logic vld = 1'b0;
	always @(posedge clk)
	begin
		vld <= mem_rd;
		if (mem_rd)
			q <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
	assign mem_rdata = vld ? q : ~q;
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the execution unit.
// Assumes: Programs sit at address 0 and end on an unsupported byte.
// Notes: Register results are read back over the register port; memory results straight from the memory model.
`timescale 1ns/1ps
module tb_top;
	import exec_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] ra = 4'h0;
	logic [15:0] wd = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdt, ma, v;
	logic mrd, mwr;
	logic [7:0] mwd, mrdt, a, n, op, b1;
	int err_count = 0;
	int n_checks = 0;
	logic [7:0] ops [13] = '{8'hC6, 8'hCE, 8'hD6, 8'hDE, 8'hE6, 8'hEE, 8'hF6, 8'hFE,
		8'hED, 8'h2F, 8'h3C, 8'h37, 8'h3F};
	always #12.5 clk = ~clk;
	block_move_search_arith_exec u_block_move_search_arith_exec (.clk(clk), .nrst(nrst),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdt),
		.mem_addr(ma), .mem_rd(mrd), .mem_wr(mwr), .mem_wdata(mwd), .mem_rdata(mrdt));
	ext_mem u_ext_mem (.clk(clk), .mem_addr(ma), .mem_rd(mrd), .mem_wr(mwr),
		.mem_wdata(mwd), .mem_rdata(mrdt));
	function automatic logic [7:0] exp_acc(input logic [7:0] o, input logic [7:0] x,
		input logic [7:0] y);
		case (o)
			8'hC6: return x + y;
			8'hCE: return x + y + 8'h01;
			8'hD6: return x - y;
			8'hDE: return x - y - 8'h01;
			8'hE6: return x & y;
			8'hEE: return x ^ y;
			8'hF6: return x | y;
			8'hED: return 8'h00 - x;
			8'h2F: return ~x;
			8'h3C: return x + 8'h01;
			default: return x;
		endcase
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic put(input logic [3:0] x, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		ra <= x;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic get(input logic [3:0] x);
		@(posedge clk);
		rd <= 1'b1;
		ra <= x;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdt;
	endtask
	task automatic run(input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] p2);
		int i;
		u_ext_mem.mem[0] = p0;
		u_ext_mem.mem[1] = p1;
		u_ext_mem.mem[2] = p2;
		u_ext_mem.mem[3] = 8'h76;
		put(REG_PC, 16'h0000);
		put(REG_CTRL, 16'h0001);
		i = 0;
		v = 16'h0000;
		while (v[STAT_DONE_BIT] !== 1'b1 && i < 3000)
		begin
			get(REG_STATUS);
			i++;
		end
		chk("status", 16'h0006, v & 16'h000F);
	endtask
	task automatic blk(input logic [7:0] o, input logic [15:0] h, input logic [15:0] d,
		input logic [15:0] c, input logic [15:0] eh, input logic [15:0] ed,
		input logic [15:0] ec, input logic ez);
		put(REG_HL, h);
		put(REG_DE, d);
		put(REG_BC, c);
		put(REG_AF, 16'h5A01);
		run(OP_EXT, o, 8'h76);
		get(REG_HL);
		chk("hl", eh, v);
		get(REG_DE);
		chk("de", ed, v);
		get(REG_BC);
		chk("bc", ec, v);
		get(REG_AF);
		if (ez !== 1'bx)
			chk("zf", {15'h0, ez}, {15'h0, v[FLAG_Z]});
		$display("test %h done", o);
	endtask
	initial
	begin
		void'($urandom(32'hdd46_fc50));
		for (int k = 0; k < 8; k++)
			u_ext_mem.mem[16'h1000 + k] = 8'($urandom);
		for (int k = 0; k < 8; k++)
			u_ext_mem.mem[16'h5000 + k] = 8'h10 + 8'(k);
		u_ext_mem.mem[16'h5002] = 8'h5A;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		get(REG_STATUS);
		chk("rst", 16'h0000, v);
		blk(8'hB0, 16'h1000, 16'h2000, 16'h0003, 16'h1003, 16'h2003, 16'h0000, 1'bx);
		for (int k = 0; k < 3; k++)
			chk("copy", 16'(u_ext_mem.mem[16'h1000 + k]), 16'(u_ext_mem.mem[16'h2000 + k]));
		blk(8'hA8, 16'h1002, 16'h3000, 16'h0005, 16'h1001, 16'h2FFF, 16'h0004, 1'bx);
		chk("copy", 16'(u_ext_mem.mem[16'h1002]), 16'(u_ext_mem.mem[16'h3000]));
		blk(8'hB8, 16'h1002, 16'h1003, 16'h0003, 16'h0FFF, 16'h1000, 16'h0000, 1'bx);
		chk("ovl", 16'(u_ext_mem.mem[16'h3000]), 16'(u_ext_mem.mem[16'h1003]));
		chk("ovl", 16'(u_ext_mem.mem[16'h2000]), 16'(u_ext_mem.mem[16'h1001]));
		blk(8'hB1, 16'h5000, 16'h0000, 16'h0006, 16'h5003, 16'h0000, 16'h0003, 1'b1);
		blk(8'hB9, 16'h5007, 16'h0000, 16'h0008, 16'h5001, 16'h0000, 16'h0002, 1'b1);
		blk(8'hA1, 16'h5000, 16'h0000, 16'h0000, 16'h5001, 16'h0000, 16'hFFFF, 1'b0);
		blk(8'hA9, 16'h5002, 16'h0000, 16'h0001, 16'h5001, 16'h0000, 16'h0000, 1'b1);
		blk(8'hB1, 16'h5003, 16'h0000, 16'h0003, 16'h5006, 16'h0000, 16'h0000, 1'b0);
		blk(8'h4A, 16'h1234, 16'h0000, 16'h1111, 16'h2346, 16'h0000, 16'h1111, 1'b0);
		blk(8'h42, 16'h1112, 16'h0000, 16'h1111, 16'h0000, 16'h0000, 16'h1111, 1'b1);
		for (int r = 0; r < 26; r++)
		begin
			op = ops[r % 13];
			a = 8'($urandom);
			n = (r > 12) ? a : 8'($urandom);
			b1 = (op inside {8'h2F, 8'h3C, 8'h37, 8'h3F}) ? 8'h76 : n;
			b1 = (op == OP_EXT) ? OP_NEGATE : b1;
			put(REG_AF, {a, 8'h01});
			run(op, b1, 8'h76);
			get(REG_AF);
			chk("acc", 16'(exp_acc(op, a, n)), 16'(v[15:8]));
			if (op == 8'hFE)
				chk("zf", 16'(a == n), 16'(v[FLAG_Z]));
			else if (!(op inside {8'h2F, 8'h37, 8'h3F}))
				chk("zf", 16'(exp_acc(op, a, n) == 8'h00), 16'(v[FLAG_Z]));
			chk("nf", 16'(op inside {8'hD6, 8'hDE, 8'hFE, 8'hED, 8'h2F}),
				16'(v[FLAG_N]));
			if (op[7:4] == 4'h3 && op[0])
				chk("cf", 16'(op == OP_SETC), 16'(v[FLAG_C]));
			$display("test %h done", op);
		end
		put(REG_IX, 16'h6000);
		u_ext_mem.mem[16'h5FFE] = 8'h21;
		put(REG_AF, 16'h1500);
		run(OP_IDX_X, 8'h86, 8'hFE);
		get(REG_AF);
		chk("idx", 16'h0036, 16'(v[15:8]));
		put(REG_HL, 16'h5005);
		run(8'h35, 8'h76, 8'h76);
		chk("dec", 16'h0014, 16'(u_ext_mem.mem[16'h5005]));
		$display("test indexed and memory operand done");
		put(REG_AF, 16'h1500);
		run(8'hC6, 8'h27, OP_DECADJ);
		get(REG_AF);
		chk("bcd", 16'h0042, 16'(v[15:8]));
		run(8'hD6, 8'h15, OP_DECADJ);
		get(REG_AF);
		chk("bcd", 16'h0027, 16'(v[15:8]));
		$display("test bcd done");
		// An abort issued while busy lets the repeat finish, then stops before the next fetch.
		u_ext_mem.mem[0] = OP_EXT;
		u_ext_mem.mem[1] = 8'hB0;
		u_ext_mem.mem[2] = 8'h76;
		put(REG_HL, 16'h1000);
		put(REG_DE, 16'h4000);
		put(REG_BC, 16'h0008);
		put(REG_PC, 16'h0000);
		put(REG_CTRL, 16'h0001);
		put(REG_CTRL, 16'h0002);
		v = 16'h0000;
		for (int i = 0; i < 300 && v[STAT_DONE_BIT] !== 1'b1; i++)
			get(REG_STATUS);
		chk("abort", 16'h000A, v & 16'h000F);
		get(REG_PC);
		chk("pc", 16'h0002, v);
		get(REG_BC);
		chk("bc", 16'h0000, v);
		chk("copy", 16'(u_ext_mem.mem[16'h1007]), 16'(u_ext_mem.mem[16'h4007]));
		$display("test abort done");
		final_report();
	end
	initial
	begin
		#1000000;
		err_count++;
		final_report();
	end
endmodule
